// file: tep_error_counters.sv
// t1/e1 receive performance counters with a wishbone register port
//
// The address map and the Wishbone slave port were left to the implementer.
`timescale 1ns/100ps
`include "tep_params.svh"

module tep_error_counters
  import tep_pkg::*;
#(
  parameter int unsigned SECOND_CYCLES =
    32'(64'(`TEP_CLK_KHZ) * 64'(`TEP_SECOND_MS)),
  parameter int unsigned T1_PERIOD_CYCLES =
    32'(64'(`TEP_CLK_KHZ) * 64'(`TEP_T1_PERIOD_US) / 64'd1000),
  parameter int unsigned E1_PERIOD_CYCLES =
    32'(64'(`TEP_CLK_KHZ) * 64'(`TEP_E1_PERIOD_US) / 64'd1000),
  parameter int unsigned CNT_W = 16
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // receive line decoder, one strobe per received bit
  input  wire logic        bit_strobe_i,
  input  wire logic        mark_i,
  input  wire logic        mark_positive_i,
  input  wire logic        subst_codeword_i,
  // framer error strobes
  input  wire logic        crc6_error_i,
  input  wire logic        ft_error_i,
  input  wire logic        fs_error_i,
  input  wire logic        fps_error_i,
  input  wire logic        crc4_error_i,
  input  wire logic        fas_word_error_i,
  input  wire logic        multiframe_strobe_i,
  input  wire logic        ebit_strobe_i,
  input  wire logic        ebit_value_i,
  // synchronizer status levels
  input  wire logic        rx_loss_of_frame_i,
  input  wire logic        fas_sync_lost_i,
  input  wire logic        crc4_sync_lost_i,
  input  wire logic        fas_search_i,
  input  wire logic        cas_mf_search_i,
  input  wire logic        crc4_mf_search_i,
  // shared update sources
  input  wire logic        shared_second_i,
  input  wire logic        ext_manual_update_i,
  output logic             second_tick_o,
  output logic             update_o
);

  localparam int unsigned NCNT = 4;

  // ---------------- configuration ----------------
  logic [`TEP_CFG_WIDTH-1:0] error_counter_config;
  logic                      manual_req;

  wire code_violation_select       = error_counter_config[`TEP_CFG_CV_SEL];
  wire framing_bit_count_select    = error_counter_config[`TEP_CFG_FBIT_SEL];
  wire fs_error_count_select       = error_counter_config[`TEP_CFG_FS_SEL];
  wire rx_zero_substitution_enable = error_counter_config[`TEP_CFG_ZSUB_EN];
  wire rx_framing_mode_select      = error_counter_config[`TEP_CFG_ESF];
  wire e1_mode                     = error_counter_config[`TEP_CFG_E1];
  wire crc4_mode                   = error_counter_config[`TEP_CFG_CRC4];
  wire shared_select               = error_counter_config[`TEP_CFG_SHARED];
  wire tep_upd_mode_t upd_mode     = tep_upd_mode_t'(
    error_counter_config[`TEP_CFG_UPD_HI:`TEP_CFG_UPD_LO]);

  // ---------------- wishbone decode ----------------
  wire wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wr    = wb_req & wb_we_i;
  wire wr_cfg   = wb_wr & (wb_adr_i == `TEP_OFS_CONFIG);
  wire wr_ctl   = wb_wr & (wb_adr_i == `TEP_OFS_CONTROL) & wb_sel_i[0];
  wire manual_w = wr_ctl & wb_dat_i[`TEP_CTL_MANUAL];

  wire [`TEP_CFG_WIDTH-1:0] next_config = {
    wb_sel_i[1] ? wb_dat_i[`TEP_CFG_WIDTH-1:8] :
                  error_counter_config[`TEP_CFG_WIDTH-1:8],
    wb_sel_i[0] ? wb_dat_i[7:0] : error_counter_config[7:0]
  };

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      error_counter_config <= `TEP_CFG_RESET;
    end else if (wr_cfg) begin
      error_counter_config <= next_config;
    end
  end

  // ---------------- update event generation ----------------
  // the period counter restarts when the period changes so the first
  // interval after a mode switch is never shorter than requested
  logic [31:0] period_cnt;
  logic [31:0] sec_cnt;
  logic        prev_short_e1;

  wire [31:0] short_limit = e1_mode ? E1_PERIOD_CYCLES : T1_PERIOD_CYCLES;
  wire        short_tick  = (period_cnt >= short_limit - 32'h1);
  wire        sec_tick    = (sec_cnt >= SECOND_CYCLES - 32'h1);

  always_ff @(posedge clk_i) begin
    if (rst_i || (prev_short_e1 != e1_mode) || short_tick) begin
      period_cnt <= 32'h0;
    end else begin
      period_cnt <= period_cnt + 32'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || sec_tick) begin
      sec_cnt <= 32'h0;
    end else begin
      sec_cnt <= sec_cnt + 32'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_short_e1 <= 1'b0;
      manual_req    <= 1'b0;
    end else begin
      prev_short_e1 <= e1_mode;
      manual_req    <= manual_w;
    end
  end

  wire manual_src = shared_select ? ext_manual_update_i : manual_req;
  wire second_src = shared_select ? shared_second_i : sec_tick;

  logic update_sel;
  always_comb begin
    case (upd_mode)
      TEP_UPD_SECOND: update_sel = second_src;
      TEP_UPD_SHORT:  update_sel = short_tick;
      TEP_UPD_MANUAL: update_sel = manual_src;
      default:        update_sel = 1'b0;
    endcase
  end

  assign second_tick_o = sec_tick;
  assign update_o      = update_sel;

  // ---------------- line violation detection ----------------
  logic       seen_mark;
  logic       last_mark_pos;
  logic       seen_viol;
  logic       last_viol_pos;
  logic [4:0] zero_run;

  wire bpv      = bit_strobe_i & mark_i & seen_mark &
                  (mark_positive_i == last_mark_pos);
  wire bpv_kept = bpv & ~(rx_zero_substitution_enable &
                          subst_codeword_i);
  // a code violation is a violation repeating the previous one's polarity
  wire cv       = bpv & seen_viol &
                  (mark_positive_i == last_viol_pos);
  wire [4:0] exz_limit = rx_zero_substitution_enable ?
                         `TEP_EXZ_B8ZS : `TEP_EXZ_PLAIN;
  wire exz      = bit_strobe_i & ~mark_i &
                  (zero_run == exz_limit - 5'h1);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seen_mark     <= 1'b0;
      last_mark_pos <= 1'b0;
      seen_viol     <= 1'b0;
      last_viol_pos <= 1'b0;
      zero_run      <= 5'h0;
    end else if (bit_strobe_i) begin
      if (mark_i) begin
        seen_mark     <= 1'b1;
        last_mark_pos <= mark_positive_i;
        zero_run      <= 5'h0;
      end else if (zero_run != 5'h1F) begin
        zero_run      <= zero_run + 5'h1;
      end
      if (bpv) begin
        seen_viol     <= 1'b1;
        last_viol_pos <= mark_positive_i;
      end
    end
  end

  // line violations are never gated by sync state
  wire ev_lv = e1_mode ?
    (code_violation_select ? cv : bpv_kept) :
    (bpv_kept | (code_violation_select & exz));

  // ---------------- path violations ----------------
  wire t1_pv = rx_framing_mode_select ? crc6_error_i :
               (ft_error_i | (fs_error_count_select & fs_error_i));
  wire e1_sync_ok = ~fas_sync_lost_i & ~crc4_sync_lost_i;
  wire ev_pv = e1_mode ? (crc4_error_i & e1_sync_ok)
                       : (t1_pv & ~rx_loss_of_frame_i);

  // ---------------- sync loss / framing errors ----------------
  wire multiframes_out_of_sync = multiframe_strobe_i & rx_loss_of_frame_i;
  wire t1_fbit = (rx_framing_mode_select ? fps_error_i : ft_error_i) &
                 ~rx_loss_of_frame_i;
  wire t1_sl   = framing_bit_count_select ? t1_fbit
                                          : multiframes_out_of_sync;
  wire e1_sl   = fas_word_error_i & ~rx_loss_of_frame_i &
                 ~fas_search_i & ~cas_mf_search_i &
                 ~crc4_mf_search_i;
  wire ev_sl   = e1_mode ? e1_sl : t1_sl;

  // ---------------- far-end block errors ----------------
  wire ev_feb = e1_mode & crc4_mode & ebit_strobe_i & ~ebit_value_i &
                e1_sync_ok;

  // ---------------- counters ----------------
  wire [NCNT-1:0] events = {ev_feb, ev_sl, ev_pv, ev_lv};
  logic [CNT_W-1:0] running [NCNT];
  logic [CNT_W-1:0] held    [NCNT];

  for (genvar i = 0; i < NCNT; i++) begin : g_cnt
    wire at_max = &running[i];
    wire [CNT_W-1:0] next_running =
      update_sel ? CNT_W'(events[i]) :
      (events[i] & ~at_max) ? running[i] + CNT_W'(1) :
      running[i];

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        running[i] <= '0;
        held[i]    <= '0;
      end else begin
        running[i] <= next_running;
        if (update_sel) begin
          held[i] <= running[i];
        end
      end
    end
  end

  // ---------------- read mux ----------------
  localparam int unsigned HALF = CNT_W / 2;

  logic [31:0] rd_data;
  always_comb begin
    case (wb_adr_i)
      `TEP_OFS_CONFIG:  rd_data = 32'(error_counter_config);
      `TEP_OFS_LV_HI:   rd_data = 32'(held[TEP_CNT_LV][CNT_W-1:HALF]);
      `TEP_OFS_LV_LO:   rd_data = 32'(held[TEP_CNT_LV][HALF-1:0]);
      `TEP_OFS_PV_HI:   rd_data = 32'(held[TEP_CNT_PV][CNT_W-1:HALF]);
      `TEP_OFS_PV_LO:   rd_data = 32'(held[TEP_CNT_PV][HALF-1:0]);
      `TEP_OFS_SL_HI:   rd_data = 32'(held[TEP_CNT_SL][CNT_W-1:HALF]);
      `TEP_OFS_SL_LO:   rd_data = 32'(held[TEP_CNT_SL][HALF-1:0]);
      `TEP_OFS_FEB_HI:  rd_data = 32'(held[TEP_CNT_FEB][CNT_W-1:HALF]);
      `TEP_OFS_FEB_LO:  rd_data = 32'(held[TEP_CNT_FEB][HALF-1:0]);
      default:          rd_data = 32'h0000_0000;
    endcase
  end

  // one wait state: ack and data both come from flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        wb_dat_o <= rd_data;
      end
    end
  end

endmodule

// file: tep_params.svh
// constants for the t1/e1 error performance counters
`ifndef TEP_PARAMS_SVH
`define TEP_PARAMS_SVH

// register byte offsets, one 32-bit word each
`define TEP_OFS_CONFIG   8'h00
`define TEP_OFS_CONTROL  8'h04
`define TEP_OFS_LV_HI    8'h08
`define TEP_OFS_LV_LO    8'h0C
`define TEP_OFS_PV_HI    8'h10
`define TEP_OFS_PV_LO    8'h14
`define TEP_OFS_SL_HI    8'h18
`define TEP_OFS_SL_LO    8'h1C
`define TEP_OFS_FEB_HI   8'h20
`define TEP_OFS_FEB_LO   8'h24

// config register fields
`define TEP_CFG_CV_SEL    0
`define TEP_CFG_FBIT_SEL  1
`define TEP_CFG_FS_SEL    2
`define TEP_CFG_ZSUB_EN   3
`define TEP_CFG_ESF       4
`define TEP_CFG_E1        5
`define TEP_CFG_CRC4      6
`define TEP_CFG_UPD_LO    7
`define TEP_CFG_UPD_HI    8
`define TEP_CFG_SHARED    9
`define TEP_CFG_WIDTH     10
`define TEP_CFG_RESET     10'h000

// control register: write 1 to request a manual update unless the config shared bit is set
`define TEP_CTL_MANUAL    0

// excessive zero thresholds
`define TEP_EXZ_PLAIN     5'h10
`define TEP_EXZ_B8ZS      5'h08

// update periods and clock rate
`define TEP_CLK_KHZ       125000
`define TEP_SECOND_MS     1000
`define TEP_T1_PERIOD_US  42000
`define TEP_E1_PERIOD_US  62500

`endif

// file: tep_pkg.sv
// types for the t1/e1 error performance counters
package tep_pkg;
  typedef enum logic [1:0] {
    TEP_UPD_SECOND = 2'h0,
    TEP_UPD_SHORT  = 2'h1,
    TEP_UPD_MANUAL = 2'h2,
    TEP_UPD_SPARE  = 2'h3
  } tep_upd_mode_t;

  typedef enum logic [1:0] {
    TEP_CNT_LV  = 2'h0,
    TEP_CNT_PV  = 2'h1,
    TEP_CNT_SL  = 2'h2,
    TEP_CNT_FEB = 2'h3
  } tep_cnt_idx_t;
endpackage

// file: tep_error_counters_chk.sv
// port assertions for the error counter block
`timescale 1ns/100ps
module tep_error_counters_chk #(
  parameter int unsigned SECOND_CYCLES = 200
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        second_tick_o,
  input wire logic        update_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [31:0] gap;
  logic        seen;
  // one flop of reset history so the first edge, with state still unknown,
  // is not judged
  logic        rst_seen = 1'b0;
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_rd_ack;
    wb_ack_o && !wb_we_i;
  endsequence
  // first tick skipped: its phase after reset is left open
  always_ff @(posedge clk_i) begin
    gap  <= (rst_i || second_tick_o) ? 32'h0 : gap + 32'h1;
    seen <= !rst_i && (seen || second_tick_o);
    rst_seen <= rst_i;
  end
  a_ack_after_req: assert property (s_req |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_rdata_holds: assert property (!wb_ack_o |-> $stable(wb_dat_o))
    else $error("read data moved without a read");
  a_count_halves: assert property (s_rd_ack ##0 wb_adr_i >= 8'h08 |->
    wb_dat_o[31:8] == 24'h0)
    else $error("count half wider than a byte");
  a_unmapped_zero: assert property (s_rd_ack ##0 wb_adr_i > 8'h24 |->
    wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_reset_quiet: assert property (disable iff (1'b0)
    rst_i && rst_seen |-> !update_o && !second_tick_o)
    else $error("update during reset");
  a_second_gap: assert property (seen |->
    second_tick_o == (gap == SECOND_CYCLES - 1))
    else $error("second tick spacing wrong");
endmodule

bind tep_error_counters tep_error_counters_chk #(
  .SECOND_CYCLES(SECOND_CYCLES)
) tep_error_counters_chk_i (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .second_tick_o(second_tick_o), .update_o(update_o)
);

// file: tep_rx_model.sv
// stand-in for the receive decoder and framer feeding the counters
`timescale 1ns/100ps
module tep_rx_model (
  input  wire logic       clk_i,
  output logic            bit_strobe_o,
  output logic            mark_o,
  output logic            mark_pos_o,
  output logic            subst_o,
  output logic [7:0]      ev_o,
  output logic            ebit_val_o,
  output logic [5:0]      stat_o
);
  initial begin
    {bit_strobe_o, mark_o, mark_pos_o, subst_o, ev_o, ebit_val_o} = '0;
    stat_o = 6'h00;
  end
  // qualifiers flip when the strobe drops so stale values never look valid
  task automatic mark(input logic pos, input logic sub);
    @(posedge clk_i);
    {bit_strobe_o, mark_o, mark_pos_o, subst_o} <= {2'b11, pos, sub};
    @(posedge clk_i);
    {bit_strobe_o, mark_o, mark_pos_o, subst_o} <= {2'b00, ~pos, ~sub};
  endtask
  task automatic zero;
    @(posedge clk_i);
    {bit_strobe_o, mark_o} <= 2'b10;
    @(posedge clk_i);
    bit_strobe_o <= 1'b0;
  endtask
  task automatic ev(input logic [7:0] e, input logic [5:0] s, input logic v);
    @(posedge clk_i);
    {ev_o, stat_o, ebit_val_o} <= {e, s, v};
    @(posedge clk_i);
    {ev_o, stat_o, ebit_val_o} <= {8'h00, 6'h00, ~v};
  endtask
endmodule

// file: tep_error_counters_tb_top.sv
// self-checking bench for the error counter block
`timescale 1ns/100ps
`include "tep_params.svh"
module tep_error_counters_tb_top;
  logic        clk_i;
  logic        rst_i;
  logic        wb_cyc;
  logic        wb_stb;
  logic        wb_we;
  logic [7:0]  wb_adr;
  logic [31:0] wb_dat;
  logic        ext_upd;
  wire  [31:0] rdat;
  wire         ack;
  wire  [7:0]  ev;
  wire  [5:0]  st;
  wire         stb_b, mk, mk_pos, sub, ebv;
  int          n_mismatch;
  int          n_tests;

  tep_error_counters #(.SECOND_CYCLES(200), .T1_PERIOD_CYCLES(60),
    .E1_PERIOD_CYCLES(80)) tep_error_counters_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .bit_strobe_i(stb_b), .mark_i(mk),
    .mark_positive_i(mk_pos), .subst_codeword_i(sub), .crc6_error_i(ev[0]),
    .ft_error_i(ev[1]), .fs_error_i(ev[2]), .fps_error_i(ev[3]),
    .crc4_error_i(ev[4]), .fas_word_error_i(ev[5]),
    .multiframe_strobe_i(ev[6]), .ebit_strobe_i(ev[7]), .ebit_value_i(ebv),
    .rx_loss_of_frame_i(st[0]), .fas_sync_lost_i(st[1]),
    .crc4_sync_lost_i(st[2]), .fas_search_i(st[3]), .cas_mf_search_i(st[4]),
    .crc4_mf_search_i(st[5]), .shared_second_i(1'b0),
    .ext_manual_update_i(ext_upd), .second_tick_o(), .update_o());
  tep_rx_model m (.clk_i(clk_i), .bit_strobe_o(stb_b), .mark_o(mk),
    .mark_pos_o(mk_pos), .subst_o(sub), .ev_o(ev), .ebit_val_o(ebv),
    .stat_o(st));

  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat} <= {2'b11, w, a, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    {wb_cyc, wb_stb} <= 2'b00;
    if (n >= 20) cmp(64'h0, 64'h1);
  endtask
  // shared mode takes the external strobe, otherwise the control write
  task automatic upd(input logic ext);
    logic [31:0] q;
    if (ext) begin
      @(posedge clk_i);
      ext_upd <= 1'b1;
      @(posedge clk_i);
      ext_upd <= 1'b0;
    end else begin
      wb(1'b1, `TEP_OFS_CONTROL, 32'h1, q);
    end
    repeat (2) @(posedge clk_i);
  endtask
  task automatic cfg(input logic [9:0] c);
    logic [31:0] q;
    wb(1'b1, `TEP_OFS_CONFIG, {22'h0, c}, q);
    upd(c[9]);
  endtask
  task automatic cnt(input logic [7:0] a, input logic [15:0] e);
    logic [31:0] h;
    logic [31:0] l;
    wb(1'b0, a, 32'h0, h);
    wb(1'b0, a + 8'h04, 32'h0, l);
    cmp({h, l}, {24'h0, e[15:8], 24'h0, e[7:0]});
  endtask

  task automatic t_reset;
    logic [31:0] q;
    wb(1'b0, `TEP_OFS_CONFIG, 32'h0, q);
    cmp({32'h0, q}, 64'h0);
    wb(1'b1, 8'h40, 32'hFFFFFFFF, q);
    wb(1'b0, 8'h40, 32'h0, q);
    cmp({32'h0, q}, 64'h0);
    wb(1'b1, `TEP_OFS_LV_HI, 32'hFF, q);
    cnt(`TEP_OFS_LV_HI, 16'h0);
  endtask
  task automatic t_bpv;
    cfg(10'h100);
    m.mark(1'b0, 1'b0);
    upd(1'b0);
    repeat (3) m.mark(1'b1, 1'b0);
    upd(1'b0);
    cnt(`TEP_OFS_LV_HI, 16'h2);
  endtask
  task automatic t_subst;
    cfg(10'h108);
    m.mark(1'b0, 1'b0);
    upd(1'b0);
    m.mark(1'b1, 1'b0);
    m.mark(1'b1, 1'b1);
    m.mark(1'b1, 1'b0);
    upd(1'b0);
    cnt(`TEP_OFS_LV_HI, 16'h1);
  endtask
  task automatic t_cv;
    cfg(10'h129);
    repeat (2) m.mark(1'b0, 1'b0);
    upd(1'b0);
    repeat (2) m.mark(1'b1, 1'b0);
    m.mark(1'b0, 1'b0);
    repeat (2) m.mark(1'b1, 1'b0);
    upd(1'b0);
    cnt(`TEP_OFS_LV_HI, 16'h1);
  endtask
  task automatic t_exz;
    cfg(10'h101);
    m.mark(1'b1, 1'b0);
    upd(1'b0);
    repeat (16) m.zero;
    upd(1'b0);
    cnt(`TEP_OFS_LV_HI, 16'h1);
    cfg(10'h109);
    m.mark(1'b0, 1'b0);
    upd(1'b0);
    repeat (8) m.zero;
    upd(1'b0);
    cnt(`TEP_OFS_LV_HI, 16'h1);
  endtask
  task automatic t_d4;
    cfg(10'h104);
    m.ev(8'h02, 6'h00, 1'b1);
    m.ev(8'h04, 6'h00, 1'b1);
    m.ev(8'h02, 6'h01, 1'b1);
    m.ev(8'h40, 6'h01, 1'b1);
    m.ev(8'h40, 6'h00, 1'b1);
    upd(1'b0);
    cnt(`TEP_OFS_PV_HI, 16'h2);
    cnt(`TEP_OFS_SL_HI, 16'h1);
  endtask
  task automatic t_esf;
    cfg(10'h312);
    m.ev(8'h01, 6'h00, 1'b1);
    m.ev(8'h02, 6'h00, 1'b1);
    m.ev(8'h08, 6'h00, 1'b1);
    m.ev(8'h08, 6'h01, 1'b1);
    upd(1'b1);
    cnt(`TEP_OFS_PV_HI, 16'h1);
    cnt(`TEP_OFS_SL_HI, 16'h1);
  endtask
  task automatic t_e1;
    cfg(10'h160);
    m.ev(8'h10, 6'h00, 1'b1);
    m.ev(8'h10, 6'h10, 1'b1);
    m.ev(8'h10, 6'h02, 1'b1);
    m.ev(8'h20, 6'h00, 1'b1);
    m.ev(8'h20, 6'h08, 1'b1);
    m.ev(8'h80, 6'h00, 1'b0);
    m.ev(8'h80, 6'h00, 1'b1);
    m.ev(8'h80, 6'h04, 1'b0);
    upd(1'b0);
    cnt(`TEP_OFS_PV_HI, 16'h1 + 16'h1);
    cnt(`TEP_OFS_SL_HI, 16'h1);
    cnt(`TEP_OFS_FEB_HI, 16'h1);
  endtask

  task automatic report_and_stop;
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  initial begin
    {rst_i, wb_cyc, wb_stb, wb_we, wb_adr, wb_dat, ext_upd} = {1'b1, 44'h0};
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_bpv;
    t_subst;
    t_cv;
    t_exz;
    t_d4;
    t_esf;
    t_e1;
    report_and_stop;
  end
  // the whole sequence needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    report_and_stop;
  end
endmodule
